//--- src/oss_map.svh
// Summary of operation
// - Frame start snapshots driver output levels
// - Serial out advances on shift clock rise
// - Serial in sampled on clock fall
// - Control byte travels most significant bit first
// - Host gives eight clocks per frame
// - Frame end loads inverted byte into latches
// - Shift chain passes any bit count
// - Host keeps clock low at frame edges
// - Clock ignored while frame is inactive
// - Frame end starts 100 us blanking
// - No fault latch-off during blanking
// - After blanking, saturating fault turns output off
// - Host open-load check: off, wait, reread
// - Host overload check: on, wait, reread
// - Host XORs readback with previous byte
`ifndef OSS_MAP_SVH
`define OSS_MAP_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define OSS_CLK_NS      10
`define OSS_BLANK_US    100
`define OSS_TSU_NS      1000
`define OSS_HALF_NS     500
`define OSS_GAP_US      5
`define OSS_NS_PER_US   1000

// ----------------------------------------
// Data layout
// ----------------------------------------
`define OSS_BYTE_W      8
`define OSS_FIFO_DEPTH  32
`define OSS_ALL_OFF     8'hFF
`define OSS_SYNC_DEPTH  3

`endif

//--- src/oss_pkg.sv
package oss_pkg;

  typedef logic [7:0] oss_byte_t;

  typedef enum logic [5:0] {
    OSS_IDLE  = 6'h01,
    OSS_SETUP = 6'h02,
    OSS_HIGH  = 6'h04,
    OSS_LOW   = 6'h08,
    OSS_HOLD  = 6'h10,
    OSS_GAP   = 6'h20
  } oss_host_state_t;

endpackage

//--- src/oss_if.sv
`timescale 1ns/100ps
interface oss_if;
  logic sclk;
  logic frame_select_n;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  // Released line idles high
  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (
    input  sclk,
    input  frame_select_n,
    input  sdi,
    output sdo,
    output sdo_oe
  );

  modport host (
    output sclk,
    output frame_select_n,
    output sdi,
    input  sdo_line
  );
endinterface

//--- src/oss_fifo.sv
`timescale 1ns/100ps
module oss_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // System
  input  wire logic             mclk,
  input  wire logic             reset,
  // Fill side
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  // Drain side
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_reg[AW] == rd_reg[AW]) || (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
  assign out_valid = (wr_reg != rd_reg);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_reg[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wr_reg <= '0;
    end else if (push) begin
      wr_reg <= wr_reg + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_reg <= '0;
    end else if (pop) begin
      rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule // oss_fifo

//--- src/oss_device.sv
`timescale 1ns/100ps
`include "oss_map.svh"
module oss_device import oss_pkg::*; #(
  parameter int unsigned CH        = `OSS_BYTE_W,
  parameter int unsigned BLANK_CYC = `OSS_BLANK_US * `OSS_NS_PER_US / `OSS_CLK_NS
) (
  // System
  input  wire logic          mclk,
  input  wire logic          reset,
  // Serial link
  oss_if.dev                 link,
  // Driver stage
  input  wire logic [CH-1:0] out_level,
  input  wire logic [CH-1:0] oos_flag,
  output logic [CH-1:0]      driver_on,
  // Diagnostics
  output logic [CH-1:0]      fault_off,
  output logic               blanking
);
  localparam int unsigned ctrl_bit_msb      = CH - 1;
  localparam int unsigned driver_output_lsb = 0;
  localparam int unsigned SD                = `OSS_SYNC_DEPTH;
  localparam int unsigned BW                = $clog2(BLANK_CYC + 1);
  localparam logic [BW-1:0] BLANK_LOAD      = BW'(BLANK_CYC - 1);

  logic [SD-1:0] fsn_sync_reg;
  logic          frame_hi_reg;
  logic          frame_fall;
  logic          frame_rise;
  logic          fsn_agree;
  logic [CH-1:0] lvl_reg;
  logic [CH-1:0] oos_reg;
  logic [CH-1:0] snap_reg;
  logic [CH-1:0] on_reg;
  logic [CH-1:0] fault_reg;
  logic [CH-1:0] trip;
  logic [BW-1:0] blank_cnt_reg;
  logic [CH-1:0] shift_reg;
  logic [CH-1:0] shift_src;
  logic          fresh_reg;
  logic          so_reg;
  logic          link_idle;

  // ----------------------------------------
  // Frame enable synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fsn_sync_reg <= '1;
    end else begin
      fsn_sync_reg <= {fsn_sync_reg[SD-2:0], link.frame_select_n};
    end
  end

  assign fsn_agree  = (fsn_sync_reg[1] == fsn_sync_reg[2]);
  assign frame_fall = fsn_agree && !fsn_sync_reg[2] && frame_hi_reg;
  assign frame_rise = fsn_agree && fsn_sync_reg[2] && !frame_hi_reg;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      frame_hi_reg <= 1'b1;
    end else if (fsn_agree) begin
      frame_hi_reg <= fsn_sync_reg[2];
    end
  end

  // ----------------------------------------
  // Output level and comparator filters
  // ----------------------------------------
  generate
    for (genvar i = 0; i < CH; i++) begin : g_pin
      logic [SD-1:0] lvl_sync_reg;
      logic [SD-1:0] oos_sync_reg;

      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          lvl_sync_reg <= '1;
        end else begin
          lvl_sync_reg <= {lvl_sync_reg[SD-2:0], out_level[i]};
        end
      end

      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          lvl_reg[i] <= 1'b1;
        end else if (lvl_sync_reg[1] == lvl_sync_reg[2]) begin
          lvl_reg[i] <= lvl_sync_reg[2];
        end
      end

      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          oos_sync_reg <= '0;
        end else begin
          oos_sync_reg <= {oos_sync_reg[SD-2:0], oos_flag[i]};
        end
      end

      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          oos_reg[i] <= 1'b0;
        end else if (oos_sync_reg[1] == oos_sync_reg[2]) begin
          oos_reg[i] <= oos_sync_reg[2];
        end
      end

      // Enabled output above threshold after blanking
      assign trip[i] = on_reg[i] && oos_reg[i] && !blanking;
    end
  endgenerate

  // ----------------------------------------
  // Readback snapshot
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      snap_reg <= `OSS_ALL_OFF;
    end else if (frame_fall) begin
      snap_reg <= lvl_reg;
    end
  end

  // ----------------------------------------
  // Output latches
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      on_reg <= '0;
    end else if (frame_rise) begin
      on_reg <= ~shift_reg;
    end else begin
      on_reg <= on_reg & ~trip;
    end
  end

  assign driver_on = on_reg;

  // Sticky per frame; cleared by the next load
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      fault_reg <= '0;
    end else if (frame_rise) begin
      fault_reg <= '0;
    end else begin
      fault_reg <= fault_reg | trip;
    end
  end

  assign fault_off = fault_reg;

  // ----------------------------------------
  // Blanking timer
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      blank_cnt_reg <= '0;
    end else if (frame_rise) begin
      blank_cnt_reg <= BLANK_LOAD;
    end else if (blank_cnt_reg != '0) begin
      blank_cnt_reg <= blank_cnt_reg - 1'b1;
    end
  end

  assign blanking = (blank_cnt_reg != '0) || frame_rise;

  // ----------------------------------------
  // Link side shift chain
  // ----------------------------------------
  // Snapshot is stable long before the first clock edge of a frame
  assign link_idle = link.frame_select_n || reset;

  always_ff @(negedge link.sclk or posedge link_idle) begin
    if (link_idle) begin
      fresh_reg <= 1'b1;
    end else begin
      fresh_reg <= 1'b0;
    end
  end

  assign shift_src = fresh_reg ? snap_reg : shift_reg;

  always_ff @(negedge link.sclk or posedge reset) begin
    if (reset) begin
      shift_reg <= `OSS_ALL_OFF;
    end else if (!link.frame_select_n) begin
      shift_reg <= {shift_src[ctrl_bit_msb-1:driver_output_lsb], link.sdi};
    end
  end

  always_ff @(posedge link.sclk or posedge reset) begin
    if (reset) begin
      so_reg <= 1'b1;
    end else if (!link.frame_select_n) begin
      so_reg <= shift_src[ctrl_bit_msb];
    end
  end

  assign link.sdo    = fresh_reg ? snap_reg[ctrl_bit_msb] : so_reg;
  assign link.sdo_oe = !link.frame_select_n;
endmodule // oss_device

//--- src/oss_host.sv
`timescale 1ns/100ps
`include "oss_map.svh"
module oss_host import oss_pkg::*; #(
  parameter int unsigned HALF_CYC = (`OSS_HALF_NS + `OSS_CLK_NS - 1) / `OSS_CLK_NS,
  parameter int unsigned TSU_CYC  = (`OSS_TSU_NS + `OSS_CLK_NS - 1) / `OSS_CLK_NS,
  parameter int unsigned GAP_CYC  = `OSS_GAP_US * `OSS_NS_PER_US / `OSS_CLK_NS,
  parameter int unsigned DEPTH    = `OSS_FIFO_DEPTH
) (
  // System
  input  wire logic      mclk,
  input  wire logic      reset,
  // Serial link
  oss_if.host            link,
  // Command stream
  input  wire oss_byte_t cmd_data,
  input  wire logic      cmd_valid,
  output logic           cmd_ready,
  // Readback
  output oss_byte_t      status_data,
  output oss_byte_t      fault_flags,
  output logic           status_valid,
  output logic           busy
);
  localparam int unsigned SD = `OSS_SYNC_DEPTH;
  localparam int unsigned NB = `OSS_BYTE_W;

  oss_host_state_t state_reg;
  logic [15:0]     timer_reg;
  logic [3:0]      bit_cnt_reg;
  oss_byte_t       tx_reg;
  oss_byte_t       rx_reg;
  oss_byte_t       cur_reg;
  oss_byte_t       prev_reg;
  logic [SD-1:0]   sdo_sync_reg;
  logic            sdo_reg;
  logic            sclk_reg;
  logic            fsn_reg;
  logic            q_valid;
  oss_byte_t       q_data;
  logic            q_pop;
  logic            tdone;

  oss_fifo #(.WIDTH(NB), .DEPTH(DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   (cmd_data),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_pop)
  );

  assign q_pop = (state_reg == OSS_IDLE);
  assign tdone = (timer_reg == '0);

  // ----------------------------------------
  // Readback synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sdo_sync_reg <= '1;
    end else begin
      sdo_sync_reg <= {sdo_sync_reg[SD-2:0], link.sdo_line};
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sdo_reg <= 1'b1;
    end else if (sdo_sync_reg[1] == sdo_sync_reg[2]) begin
      sdo_reg <= sdo_sync_reg[2];
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg    <= OSS_IDLE;
      timer_reg    <= '0;
      bit_cnt_reg  <= '0;
      tx_reg       <= `OSS_ALL_OFF;
      rx_reg       <= '0;
      cur_reg      <= `OSS_ALL_OFF;
      prev_reg     <= `OSS_ALL_OFF;
      sclk_reg     <= 1'b0;
      fsn_reg      <= 1'b1;
      status_data  <= '0;
      fault_flags  <= '0;
      status_valid <= 1'b0;
    end else begin
      status_valid <= 1'b0;
      if (!tdone) begin
        timer_reg <= timer_reg - 1'b1;
      end
      unique case (state_reg)
        OSS_IDLE: begin
          if (q_valid) begin
            tx_reg      <= q_data;
            cur_reg     <= q_data;
            bit_cnt_reg <= '0;
            fsn_reg     <= 1'b0;
            timer_reg   <= 16'(TSU_CYC - 1);
            state_reg   <= OSS_SETUP;
          end
        end
        OSS_SETUP: begin
          if (tdone) begin
            sclk_reg  <= 1'b1;
            timer_reg <= 16'(HALF_CYC - 1);
            state_reg <= OSS_HIGH;
          end
        end
        OSS_HIGH: begin
          if (tdone) begin
            sclk_reg    <= 1'b0;
            rx_reg      <= {rx_reg[NB-2:0], sdo_reg};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == 4'(NB - 1)) begin
              timer_reg <= 16'(TSU_CYC - 1);
              state_reg <= OSS_HOLD;
            end else begin
              timer_reg <= 16'(HALF_CYC - 1);
              state_reg <= OSS_LOW;
            end
          end
        end
        OSS_LOW: begin
          if (tdone) begin
            sclk_reg  <= 1'b1;
            tx_reg    <= {tx_reg[NB-2:0], 1'b1};
            timer_reg <= 16'(HALF_CYC - 1);
            state_reg <= OSS_HIGH;
          end
        end
        OSS_HOLD: begin
          if (tdone) begin
            fsn_reg      <= 1'b1;
            status_data  <= rx_reg;
            fault_flags  <= rx_reg ^ prev_reg;
            prev_reg     <= cur_reg;
            status_valid <= 1'b1;
            timer_reg    <= 16'(GAP_CYC - 1);
            state_reg    <= OSS_GAP;
          end
        end
        OSS_GAP: begin
          if (tdone) begin
            state_reg <= OSS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.sclk           = sclk_reg;
  assign link.frame_select_n = fsn_reg;
  assign link.sdi            = tx_reg[NB-1];
  assign busy                = (state_reg != OSS_IDLE);
endmodule // oss_host

//--- tb/oss_properties.sv
`timescale 1ns/100ps
module oss_properties (
  // System
  input wire logic mclk,
  input wire logic reset,
  // Serial link
  input wire logic sclk,
  input wire logic frame_select_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  logic       sclk_d_reg;
  logic [3:0] rise_cnt_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Shift clock edge bookkeeping
  // ----------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      sclk_d_reg <= 1'b0;
    else
      sclk_d_reg <= sclk;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      rise_cnt_reg <= 4'h0;
    else if (frame_select_n)
      rise_cnt_reg <= 4'h0;
    else if (sclk && !sclk_d_reg)
      rise_cnt_reg <= rise_cnt_reg + 4'h1;
  end

  // ----------------------------------------
  // Link rules
  // ----------------------------------------
  oe_follows_a: assert property (sdo_oe == !frame_select_n)
    else $error("serial out enable does not follow frame select");
  clk_low_edges_a: assert property ($changed(frame_select_n) |-> !sclk && !$past(sclk))
    else $error("shift clock high at a frame edge");
  setup_low_a: assert property ($fell(frame_select_n) |-> !sclk [*6])
    else $error("shift clock rose too soon after frame start");
  hold_low_a: assert property ($rose(frame_select_n) |-> !$past(sclk, 6))
    else $error("frame ended too soon after last clock");
  eight_clocks_a: assert property ($rose(frame_select_n) |-> rise_cnt_reg == 4'h8)
    else $error("frame did not carry eight clocks");
  idle_clk_a: assert property (frame_select_n && $past(frame_select_n) |-> !sclk)
    else $error("shift clock active outside a frame");
  sdi_stable_a: assert property ($fell(sclk) |-> $stable(sdi) [*4])
    else $error("serial in moved around a falling clock");
  sdo_timing_a: assert property ($changed(sdo) && !frame_select_n && !$past(frame_select_n, 8)
                                 |-> sclk && !sclk_d_reg)
    else $error("serial out moved away from a rising clock");
  frame_gap_a: assert property ($rose(frame_select_n) |-> frame_select_n [*8])
    else $error("frames too close together");
endmodule // oss_properties

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import oss_pkg::*;
  logic       mclk;
  logic       reset;
  oss_byte_t  cmd_data;
  logic       cmd_valid;
  logic       cmd_ready;
  oss_byte_t  status_data;
  oss_byte_t  fault_flags;
  logic       status_valid;
  logic       busy;
  logic [7:0] out_level;
  logic [7:0] oos_flag;
  logic [7:0] driver_on;
  logic [7:0] fault_off;
  logic       blanking;
  logic [7:0] open_mask;
  logic [7:0] over_mask;
  logic       saw_full;
  oss_byte_t  sent[$];
  oss_byte_t  prev;
  oss_byte_t  cur;
  integer     seed;
  int         fail_count;
  int         checked;

  oss_if link ();
  oss_host #(.HALF_CYC(5), .TSU_CYC(8), .GAP_CYC(8)) i_oss_host (
    .mclk(mclk), .reset(reset), .link(link), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .status_data(status_data), .fault_flags(fault_flags),
    .status_valid(status_valid), .busy(busy));
  oss_device #(.BLANK_CYC(50)) i_oss_device (
    .mclk(mclk), .reset(reset), .link(link), .out_level(out_level), .oos_flag(oos_flag),
    .driver_on(driver_on), .fault_off(fault_off), .blanking(blanking));
  oss_properties i_oss_properties (
    .mclk(mclk), .reset(reset), .sclk(link.sclk), .frame_select_n(link.frame_select_n),
    .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // Load model: open loads pull low, overloads stay high
  // ----------------------------------------
  always @(negedge mclk) begin
    out_level <= (~driver_on & ~open_mask) | over_mask;
    oos_flag  <= over_mask & driver_on;
  end

  function automatic oss_byte_t exp_status(input oss_byte_t p);
    return (p & ~open_mask) | over_mask;
  endfunction

  task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task close_out;
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic send(input oss_byte_t b);
    int n;
    @(negedge mclk);
    cmd_data = b;
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      saw_full = 1'b1;
      n++;
      @(negedge mclk);
    end
    if (n == 3000) begin
      check8("cmd_ready", 8'h01, 8'h00);
      close_out();
    end
    sent.push_back(b);
    @(posedge mclk);
  endtask

  task automatic drain;
    int n;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while ((sent.size() != 0 || busy !== 1'b0) && n < 20000) begin
      n++;
      @(negedge mclk);
    end
    if (n == 20000) begin
      check8("busy", 8'h00, 8'h01);
      close_out();
    end
    repeat (10) @(negedge mclk);
  endtask

  // ----------------------------------------
  // Readback and latch monitor
  // ----------------------------------------
  always @(negedge mclk) begin
    if (status_valid === 1'b1) begin
      cur = sent.pop_front();
      check8("status_data", exp_status(prev), status_data);
      check8("fault_flags", exp_status(prev) ^ prev, fault_flags);
      prev = cur;
      repeat (6) @(negedge mclk);
      check8("driver_on", ~cur, driver_on);
      check8("blanking", 8'h01, {7'h00, blanking});
    end
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    seed = 60813;
    cmd_valid = 1'b0;
    cmd_data = 8'h00;
    open_mask = 8'h00;
    over_mask = 8'h00;
    out_level = 8'hFF;
    oos_flag = 8'h00;
    prev = 8'hFF;
    saw_full = 1'b0;
    fail_count = 0;
    checked = 0;
    repeat (5) @(negedge mclk);
    reset = 1'b0;
    send(8'h00);
    send(8'hFF);
    send(8'hA5);
    send(8'h80);
    for (int i = 0; i < 40; i++)
      send(oss_byte_t'($random(seed)));
    drain();
    check8("fifo_full", 8'h01, {7'h00, saw_full});
    over_mask = 8'h04;
    send(8'hFB);
    drain();
    repeat (12) @(negedge mclk);
    check8("driver_on", 8'h04, driver_on);
    repeat (45) @(negedge mclk);
    check8("driver_on", 8'h00, driver_on);
    check8("fault_off", 8'h04, fault_off);
    check8("blanking", 8'h00, {7'h00, blanking});
    send(8'hFF);
    drain();
    over_mask = 8'h00;
    open_mask = 8'h10;
    send(8'hFF);
    send(8'h00);
    drain();
    open_mask = 8'h00;
    send(8'h3C);
    drain();
    close_out();
  end
endmodule // tb_top
